// *** rtl/usdp_top.sv ***
// uart shadow data port: ahb-lite slave, queues, serial lines
// Contract
// - sixteen word aliases all reach the same receive/transmit data path
// - normal mode uses serial pins, infrared mode the infrared pins
// - read data is valid only while the data-available flag is set
// - fifos off: new character overwrites unread one and flags overrun
// - fifos on: a read returns and consumes the receive queue head; a read right behind another returns the same byte again
// - receive queue full: keep contents, drop newcomer, flag overrun
// - fifos off, holding empty: one write clears holding-empty
// - fifos off: later writes before empty again overwrite the character
// - fifos on: writes accepted until the transmit queue is full
// - write to a full transmit queue is discarded, queue unchanged
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "usdp_defs.svh"
module usdp_top #(
    parameter int DEPTH = `USDP_FIFO_DEPTH,
    parameter logic [15:0] BAUD_DIV = `USDP_BAUD_DIV
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ser_in,
    input wire logic ir_in,
    output logic ser_out,
    output logic ir_out_n,
    output logic irq
);
    import usdp_pkg::*;
    initial begin
        if (BAUD_DIV == 16'h0000) begin
            $error("baud divider must be nonzero");
        end
    end
    typedef struct packed {
        usdp_phase_e ph;
        logic [31:0] addr;
        logic [31:0] rdata;
        usdp_ctrl_s ctrl;
        logic [7:0] rx_hold;
        logic avail;
        logic oe;
        logic [7:0] tx_hold;
        logic hold_empty; // single-char holding empty
        logic empty_q; // idle-empty level one cycle ago
        logic [15:0] div;
        logic tick;
        logic [2:0] sin_sy;
        logic [2:0] sir_sy;
        usdp_evt_s irq_st;
        usdp_evt_s irq_mask;
    } usdp_top_s;
    usdp_top_s st_ff;
    usdp_top_s nxt_st;
    logic [7:0] rxq_dout;
    logic [7:0] txq_dout;
    logic rxq_full, rxq_empty, txq_full, txq_empty;
    logic rxq_push, rxq_pop, txq_push, txq_pop;
    logic [7:0] rx_char;
    logic rx_done, tx_busy, tx_line, tx_go, line_in;
    logic [7:0] tx_char;
    logic addr_ok, is_alias, rd_alias, wr_alias;
    logic avail_now, hold_empty_now;
    logic [31:0] rd_word;
    logic [7:0] wbyte;
    logic qflush;
    // data phase decode; every access is one wait-free data phase
    assign is_alias = st_ff.addr >= `USDP_ALIAS_BASE &&
        st_ff.addr <= `USDP_ALIAS_LAST;
    assign rd_alias = st_ff.ph == USDP_RD && is_alias;
    assign wr_alias = st_ff.ph == USDP_WR && is_alias;
    assign wbyte = hwdata[7:0];
    assign addr_ok = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    // mode select: only the active pair is live
    assign line_in = st_ff.ctrl.ir_mode ? st_ff.sir_sy[2] :
        st_ff.sin_sy[2];
    assign ser_out = st_ff.ctrl.ir_mode ? 1'b1 : tx_line;
    assign ir_out_n = st_ff.ctrl.ir_mode ? tx_line : 1'b1;
    assign avail_now = st_ff.ctrl.fifo_en ? !rxq_empty : st_ff.avail;
    assign hold_empty_now = st_ff.ctrl.fifo_en ? txq_empty :
        st_ff.hold_empty;
    assign qflush = !st_ff.ctrl.fifo_en;
    assign rxq_push = rx_done && st_ff.ctrl.fifo_en;
    assign rxq_pop = rd_alias && st_ff.ctrl.fifo_en;
    assign txq_push = wr_alias && st_ff.ctrl.fifo_en;
    assign tx_go = !tx_busy && (st_ff.ctrl.fifo_en ? !txq_empty :
        !st_ff.hold_empty);
    assign tx_char = st_ff.ctrl.fifo_en ? txq_dout : st_ff.tx_hold;
    assign txq_pop = tx_go && st_ff.ctrl.fifo_en;
    assign irq = |(st_ff.irq_st & st_ff.irq_mask);
    // read mux, computed in the address phase
    always_comb begin
        rd_word = `USDP_RESET_WORD;
        if (haddr >= `USDP_ALIAS_BASE && haddr <= `USDP_ALIAS_LAST) begin
            rd_word[7:0] = st_ff.ctrl.fifo_en ? rxq_dout :
                st_ff.rx_hold;
        end else if (haddr == `USDP_CTRL_OFS) begin
            rd_word[`USDP_FIFO_EN_BIT] = st_ff.ctrl.fifo_en;
            rd_word[`USDP_IR_MODE_BIT] = st_ff.ctrl.ir_mode;
        end else if (haddr == `USDP_STAT_OFS) begin
            rd_word[`USDP_AVAIL_BIT] = avail_now;
            rd_word[`USDP_OE_BIT] = st_ff.oe;
            rd_word[`USDP_HOLD_EMPTY_BIT] = hold_empty_now;
        end else if (haddr == `USDP_IRQ_OFS) begin
            rd_word[2:0] = st_ff.irq_st;
        end else if (haddr == `USDP_MASK_OFS) begin
            rd_word[2:0] = st_ff.irq_mask;
        end
    end
    // next-state: bus, receive holding, transmit holding, events
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sin_sy = {st_ff.sin_sy[1:0], ser_in};
        nxt_st.sir_sy = {st_ff.sir_sy[1:0], ir_in};
        nxt_st.tick = 1'b0;
        nxt_st.div = st_ff.div + 16'h0001;
        if (st_ff.div == BAUD_DIV - 16'h0001) begin
            nxt_st.div = '0;
            nxt_st.tick = 1'b1;
        end
        nxt_st.ph = USDP_IDLE;
        if (addr_ok) begin
            nxt_st.addr = haddr;
            nxt_st.ph = hwrite ? USDP_WR : USDP_RD;
            if (!hwrite) begin
                nxt_st.rdata = rd_word;
            end
        end
        // a read of the status word clears the overrun flag
        if (st_ff.ph == USDP_RD && st_ff.addr == `USDP_STAT_OFS) begin
            nxt_st.oe = 1'b0;
        end
        if (rd_alias && !st_ff.ctrl.fifo_en) begin
            nxt_st.avail = 1'b0;
        end
        if (rx_done) begin
            if (!st_ff.ctrl.fifo_en) begin
                nxt_st.rx_hold = rx_char;
                nxt_st.avail = 1'b1;
                if (st_ff.avail && !rd_alias) begin
                    nxt_st.oe = 1'b1;
                end
            end else if (rxq_full && !rxq_pop) begin
                nxt_st.oe = 1'b1;
            end
        end
        if (tx_go && !st_ff.ctrl.fifo_en) begin
            nxt_st.hold_empty = 1'b1;
        end
        if (wr_alias && !st_ff.ctrl.fifo_en) begin
            nxt_st.tx_hold = wbyte;
            nxt_st.hold_empty = 1'b0;
        end
        if (st_ff.ph == USDP_WR) begin
            if (st_ff.addr == `USDP_CTRL_OFS) begin
                nxt_st.ctrl.fifo_en = hwdata[`USDP_FIFO_EN_BIT];
                nxt_st.ctrl.ir_mode = hwdata[`USDP_IR_MODE_BIT];
                if (hwdata[`USDP_FIFO_EN_BIT] != st_ff.ctrl.fifo_en) begin
                    nxt_st.avail = 1'b0;
                    nxt_st.hold_empty = 1'b1;
                end
            end
            if (st_ff.addr == `USDP_MASK_OFS) begin
                nxt_st.irq_mask = hwdata[2:0];
            end
            if (st_ff.addr == `USDP_IRQ_OFS) begin
                nxt_st.irq_st = st_ff.irq_st & ~hwdata[2:0];
            end
        end
        // sticky events; a set in the clear cycle wins
        if (nxt_st.oe && !st_ff.oe) begin
            nxt_st.irq_st.overrun = 1'b1;
        end
        if (rx_done) begin
            nxt_st.irq_st.rx_avail = 1'b1;
        end
        // edge, not level, so a write-one clear of tx_empty can stick
        nxt_st.empty_q = hold_empty_now && !tx_busy;
        if (nxt_st.empty_q && !st_ff.empty_q) begin
            nxt_st.irq_st.tx_empty = 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.hold_empty <= 1'b1;
            st_ff.sin_sy <= 3'b111;
            st_ff.sir_sy <= 3'b111;
        end else begin
            st_ff <= nxt_st;
        end
    end
    usdp_queue #(.DEPTH(DEPTH)) u_rxq (
        .hclk(hclk),
        .hresetn(hresetn),
        .flush(qflush),
        .push(rxq_push),
        .din(rx_char),
        .pop(rxq_pop),
        .dout(rxq_dout),
        .full(rxq_full),
        .empty(rxq_empty)
    );
    usdp_queue #(.DEPTH(DEPTH)) u_txq (
        .hclk(hclk),
        .hresetn(hresetn),
        .flush(qflush),
        .push(txq_push),
        .din(wbyte),
        .pop(txq_pop),
        .dout(txq_dout),
        .full(txq_full),
        .empty(txq_empty)
    );
    usdp_serial u_ser (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick16(st_ff.tick),
        .rx_line(line_in),
        .rx_char(rx_char),
        .rx_done(rx_done),
        .tx_go(tx_go),
        .tx_char(tx_char),
        .tx_busy(tx_busy),
        .tx_line(tx_line)
    );
    // assertions
    property p_alias_same;
        @(posedge hclk) disable iff (!hresetn)
        rd_alias && !st_ff.ctrl.fifo_en |-> hrdata[7:0] == st_ff.rx_hold
            || $past(rx_done);
    endproperty
    a_alias_same: assert property (p_alias_same)
        else $error("alias read does not return holding byte");
    property p_upper_zero;
        @(posedge hclk) disable iff (!hresetn)
        rd_alias |-> hrdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("reserved alias bits not zero");
    property p_mode_idle;
        @(posedge hclk) disable iff (!hresetn)
        st_ff.ctrl.ir_mode |-> ser_out;
    endproperty
    a_mode_idle: assert property (p_mode_idle)
        else $error("serial output active in infrared mode");
    property p_avail_set;
        @(posedge hclk) disable iff (!hresetn)
        rx_done && !st_ff.ctrl.fifo_en ##1 !$changed(st_ff.ctrl) |->
            st_ff.avail;
    endproperty
    a_avail_set: assert property (p_avail_set)
        else $error("data-available not set after receive");
    property p_overrun;
        @(posedge hclk) disable iff (!hresetn)
        rx_done && !st_ff.ctrl.fifo_en && st_ff.avail && !rd_alias |=>
            st_ff.oe;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overwrite without overrun");
    property p_full_drop;
        @(posedge hclk) disable iff (!hresetn)
        rx_done && st_ff.ctrl.fifo_en && rxq_full && !rxq_pop |=>
            st_ff.oe && rxq_full;
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("full receive queue not preserved");
    property p_empty_clr;
        @(posedge hclk) disable iff (!hresetn)
        wr_alias && !st_ff.ctrl.fifo_en && !tx_go |=> !st_ff.hold_empty;
    endproperty
    a_empty_clr: assert property (p_empty_clr)
        else $error("holding-empty not cleared by write");
    property p_tx_full;
        @(posedge hclk) disable iff (!hresetn)
        txq_push && txq_full && !txq_pop |=> txq_full;
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("full transmit queue changed");
endmodule

// *** rtl/usdp_defs.svh ***
// constants for the uart shadow data port
`ifndef USDP_DEFS_SVH
`define USDP_DEFS_SVH
`define USDP_ALIAS_BASE 32'h5000_1030
`define USDP_ALIAS_4 32'h5000_1040
`define USDP_ALIAS_5 32'h5000_1044
`define USDP_ALIAS_LAST 32'h5000_106C
`define USDP_CTRL_OFS 32'h5000_1070
`define USDP_STAT_OFS 32'h5000_1074
`define USDP_IRQ_OFS 32'h5000_1078
`define USDP_MASK_OFS 32'h5000_107C
`define USDP_FIFO_EN_BIT 0
`define USDP_IR_MODE_BIT 1
`define USDP_AVAIL_BIT 0
`define USDP_OE_BIT 1
`define USDP_HOLD_EMPTY_BIT 5
`define USDP_BAUD_DIV 16'h0015
`define USDP_FIFO_DEPTH 16
`define USDP_CHAR_W 8
`define USDP_RESET_WORD 32'h0000_0000
`endif

// *** rtl/usdp_pkg.sv ***
// types shared by the uart shadow data port
package usdp_pkg;
    typedef struct packed {
        logic fifo_en;
        logic ir_mode;
    } usdp_ctrl_s;
    typedef struct packed {
        logic overrun;
        logic rx_avail;
        logic tx_empty;
    } usdp_evt_s;
    typedef enum logic [1:0] {
        USDP_IDLE,
        USDP_RD,
        USDP_WR
    } usdp_phase_e;
endpackage

// *** rtl/usdp_queue.sv ***
// character queue used for both directions
`timescale 1ns/1ps
`include "usdp_defs.svh"
module usdp_queue #(
    parameter int DEPTH = `USDP_FIFO_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] din,
    input wire logic pop,
    output logic [7:0] dout,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("queue depth must be a power of two, at least 2");
        end
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } usdp_q_s;
    usdp_q_s st_ff;
    usdp_q_s nxt_st;
    logic [7:0] mem [DEPTH];
    // pointers carry one extra bit so full and empty differ
    assign empty = st_ff.wp == st_ff.rp;
    assign full = (st_ff.wp[AW] != st_ff.rp[AW]) &&
        (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
    assign dout = mem[st_ff.rp[AW-1:0]];
    // push while full is dropped, contents kept; a pop frees the slot
    always_comb begin
        nxt_st = st_ff;
        if (flush) begin
            nxt_st.wp = '0;
            nxt_st.rp = '0;
        end else begin
            if (push && (!full || pop)) begin
                nxt_st.wp = st_ff.wp + 1'b1;
            end
            if (pop && !empty) begin
                nxt_st.rp = st_ff.rp + 1'b1;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // storage has no reset; dout still shows the entry at the read pointer when empty
    always_ff @(posedge hclk) begin
        if (push && (!full || pop) && !flush) begin
            mem[st_ff.wp[AW-1:0]] <= din;
        end
    end
endmodule

// *** rtl/usdp_serial.sv ***
// 8n1 serial engine, rx and tx, on a baud enable
`timescale 1ns/1ps
`include "usdp_defs.svh"
module usdp_serial (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick16,
    input wire logic rx_line,
    output logic [7:0] rx_char,
    output logic rx_done,
    input wire logic tx_go,
    input wire logic [7:0] tx_char,
    output logic tx_busy,
    output logic tx_line
);
    typedef struct packed {
        logic rx_on;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_char;
        logic rx_done;
        logic tx_on;
        logic [3:0] tx_sub;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
    } usdp_ser_s;
    usdp_ser_s st_ff;
    usdp_ser_s nxt_st;
    assign rx_char = st_ff.rx_char;
    assign rx_done = st_ff.rx_done;
    assign tx_busy = st_ff.tx_on;
    assign tx_line = st_ff.tx_on ? st_ff.tx_sh[0] : 1'b1;
    // sample mid bit: 8 subticks after start edge, then every 16
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_done = 1'b0;
        if (tx_go && !st_ff.tx_on) begin
            nxt_st.tx_on = 1'b1;
            nxt_st.tx_sh = {1'b1, tx_char, 1'b0};
            nxt_st.tx_sub = '0;
            nxt_st.tx_bit = '0;
        end
        if (tick16) begin
            if (!st_ff.rx_on && !rx_line) begin
                nxt_st.rx_on = 1'b1;
                nxt_st.rx_sub = 4'h8;
                nxt_st.rx_bit = '0;
            end else if (st_ff.rx_on) begin
                nxt_st.rx_sub = st_ff.rx_sub + 1'b1;
                if (st_ff.rx_sub == 4'hF) begin
                    nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
                    if (st_ff.rx_bit == 4'h0 && rx_line) begin
                        nxt_st.rx_on = 1'b0; // false start
                    end else if (st_ff.rx_bit == 4'h9) begin
                        nxt_st.rx_on = 1'b0;
                        nxt_st.rx_char = st_ff.rx_sh;
                        nxt_st.rx_done = rx_line; // framing errors dropped
                    end else if (st_ff.rx_bit != 4'h0) begin
                        nxt_st.rx_sh = {rx_line, st_ff.rx_sh[7:1]};
                    end
                end
            end
            if (st_ff.tx_on) begin
                nxt_st.tx_sub = st_ff.tx_sub + 1'b1;
                if (st_ff.tx_sub == 4'hF) begin
                    nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
                    nxt_st.tx_bit = st_ff.tx_bit + 1'b1;
                    if (st_ff.tx_bit == 4'h9) begin
                        nxt_st.tx_on = 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// *** sim/usdp_far_end.sv ***
// remote serial end: 8n1 sender and receiver on serial or ir pins
`timescale 1ns/1ps
module usdp_far_end #(
    parameter int BIT_CYC = 32
) (
    input wire logic hclk,
    input wire logic ir_sel,
    input wire logic ser_rx,
    input wire logic ir_rx,
    output logic ser_tx,
    output logic ir_tx
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    logic line;
    // listen only on the pin that the current mode uses
    assign line = ir_sel ? ir_rx : ser_rx;
    // both lines rest at the idle mark level between frames
    initial begin
        ser_tx = 1'b1;
        ir_tx = 1'b1;
    end
    // one frame, lsb first; the unused pin stays idle
    task automatic send(input logic [7:0] c);
        logic [9:0] fr;
        fr = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            if (ir_sel) begin
                ir_tx <= fr[i];
            end else begin
                ser_tx <= fr[i];
            end
            repeat (BIT_CYC) @(posedge hclk);
        end
    endtask
    // mid-bit sampling; a broken stop bit drops the frame
    always begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge hclk);
        if (line === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge hclk);
                sh[i] = line;
            end
            repeat (BIT_CYC) @(posedge hclk);
            if (line === 1'b1) begin
                got_q.push_back(sh);
            end
        end
    end
endmodule

// *** sim/tb_top.sv ***
// testbench: ahb-lite tasks and scenarios for the shadow data port
`timescale 1ns/1ps
`include "usdp_defs.svh"
module tb_top;
    localparam int DEPTH = 4;
    localparam int BIT_CYC = 32; // 16 ticks times divider 2
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ser_in, ir_in, ser_out, ir_out_n, irq, ir_sel;
    int fail_count, check_count, n;
    // small depth and divider keep frames and fills short
    usdp_top #(.DEPTH(DEPTH), .BAUD_DIV(16'h0002)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ser_in(ser_in),
        .ir_in(ir_in), .ser_out(ser_out), .ir_out_n(ir_out_n),
        .irq(irq));
    usdp_far_end #(.BIT_CYC(BIT_CYC)) u_far (
        .hclk(hclk), .ir_sel(ir_sel), .ser_rx(ser_out),
        .ir_rx(ir_out_n), .ser_tx(ser_in), .ir_tx(ir_in));
    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; the slave's hready decides every step
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hwrite <= w;
        haddr <= a;
        htrans <= 2'b10;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task automatic wait_got(input int k);
        for (int i = 0; i < 20000 && u_far.got_q.size() < k; i++) begin
            @(posedge hclk);
        end
        // a wait that runs out is a mismatch and ends the run
        if (u_far.got_q.size() < k) begin
            $display("BAD frames expected %0d seen %0d", k,
                u_far.got_q.size());
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog: the whole run needs about 6000 cycles
    initial begin
        repeat (60000) @(posedge hclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        hresetn = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        ir_sel = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("ser_out idle", 32'(ser_out), 32'h0000_0001);
        chk("irq idle", 32'(irq), 32'h0000_0000);
        rdc("alias reset", `USDP_ALIAS_4, 32'h0000_0000);
        xfer(1'b1, 32'h5000_1080, 32'h0000_00FF);
        rdc("unmapped", 32'h5000_1080, 32'h0000_0000);
        $display("test reset done");
        // queues off: third write replaces the pending second one
        xfer(1'b1, `USDP_CTRL_OFS, 32'h0000_0000);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("holding empty first", rd & 32'h0000_0020, 32'h0000_0020);
        xfer(1'b1, `USDP_ALIAS_BASE, 32'hFFFF_FF41);
        xfer(1'b1, `USDP_ALIAS_BASE + 32'h4, 32'h0000_0042);
        xfer(1'b1, `USDP_ALIAS_LAST, 32'h0000_0043);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("holding empty low", rd & 32'h0000_0020, 32'h0000_0000);
        wait_got(2);
        repeat (BIT_CYC * 12) @(posedge hclk);
        chk("tx count", 32'(u_far.got_q.size()), 32'h0000_0002);
        chk("tx first", 32'(u_far.got_q[0]), 32'h0000_0041);
        chk("tx second", 32'(u_far.got_q[1]), 32'h0000_0043);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("holding empty high", rd & 32'h0000_0020, 32'h0000_0020);
        $display("test unbuffered tx done");
        // queues off: a second arrival overwrites the unread one
        u_far.send(8'h11);
        u_far.send(8'h22);
        repeat (8) @(posedge hclk);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("overrun and ready", rd & 32'h0000_0003, 32'h0000_0003);
        rdc("rx newest", `USDP_ALIAS_4, 32'h0000_0022);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("ready after read", rd & 32'h0000_0001, 32'h0000_0000);
        $display("test unbuffered rx done");
        // queues on: one arrival too many is dropped, head kept
        xfer(1'b1, `USDP_CTRL_OFS, 32'h0000_0001);
        for (int i = 0; i <= DEPTH; i++) begin
            u_far.send(8'h30 + 8'(i));
        end
        repeat (8) @(posedge hclk);
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("rx full overrun", rd & 32'h0000_0003, 32'h0000_0003);
        for (int i = 0; i < DEPTH; i++) begin
            rdc("rx queue", `USDP_ALIAS_BASE + 32'(4 * i), 32'h30 + i);
        end
        xfer(1'b0, `USDP_STAT_OFS, 32'h0000_0000);
        chk("rx drained", rd & 32'h0000_0001, 32'h0000_0000);
        $display("test queued rx done");
        // queues on: writes past a full queue are lost
        u_far.got_q.delete();
        for (int i = 0; i < DEPTH + 3; i++) begin
            xfer(1'b1, `USDP_ALIAS_BASE + 32'(4 * i), 32'h60 + i);
        end
        wait_got(DEPTH);
        repeat (BIT_CYC * 12) @(posedge hclk);
        n = u_far.got_q.size();
        chk("tx kept", 32'(n >= DEPTH && n <= DEPTH + 1), 32'h1);
        for (int i = 0; i < n; i++) begin
            chk("tx order", 32'(u_far.got_q[i]), 32'h60 + i);
        end
        $display("test queued tx done");
        // infrared mode with the receive interrupt unmasked
        u_far.got_q.delete();
        xfer(1'b1, `USDP_CTRL_OFS, 32'h0000_0003);
        ir_sel <= 1'b1;
        xfer(1'b1, `USDP_MASK_OFS, 32'h0000_0002);
        xfer(1'b1, `USDP_IRQ_OFS, 32'h0000_0007);
        @(posedge hclk);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        u_far.send(8'h5A);
        repeat (8) @(posedge hclk);
        chk("irq raised", 32'(irq), 32'h0000_0001);
        rdc("ir rx", `USDP_ALIAS_5, 32'h0000_005A);
        xfer(1'b1, `USDP_IRQ_OFS, 32'h0000_0007);
        @(posedge hclk);
        chk("irq cleared", 32'(irq), 32'h0000_0000);
        xfer(1'b1, `USDP_ALIAS_4, 32'h0000_00C3);
        wait_got(1);
        chk("ir tx", 32'(u_far.got_q[0]), 32'h0000_00C3);
        chk("ser_out held", 32'(ser_out), 32'h0000_0001);
        $display("test infrared done");
        tally_and_finish();
    end
endmodule
